// File: design/serial_status.sv
`timescale 1ns/1ps
module serial_status
	import serial_status_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response.
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read.
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Transmit shifter.
	output logic [CHAR_W-1:0] tx_char,
	output logic tx_char_valid,
	input wire logic tx_char_taken,
	input wire logic tx_shift_busy,
	output logic tx_enabled,
	// LIN engine.
	output logic [3:0] serial_mode_sel,
	input wire lin_events_type lin_events,
	input wire logic lin_line_in,
	// Interrupt.
	output logic irq
);

	if (ADDR_W < 12) begin : g_addr_check
		$error("ADDR_W must be at least 12");
	end

	function automatic int rw_index(input logic [ADDR_W-1:0] a);
		rw_index = RW_COUNT;
		for (int i = 0; i < RW_COUNT; i++) begin
			if (a[11:2] == RW_OFFSET[i][11:2] && (a >> 12) == '0) begin
				rw_index = i;
			end
		end
	endfunction : rw_index

	function automatic logic reads_zero(input logic [ADDR_W-1:0] a);
		reads_zero = 1'b0;
		for (int i = 0; i < RZ_COUNT; i++) begin
			if (a[11:2] == RZ_OFFSET[i][11:2] && (a >> 12) == '0) begin
				reads_zero = 1'b1;
			end
		end
	endfunction : reads_zero

	function automatic logic is_reg(input logic [ADDR_W-1:0] a,
		input logic [11:0] ofs);
		is_reg = (a[11:2] == ofs[11:2]) && ((a >> 12) == '0);
	endfunction : is_reg

	// Write channel state.
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic awready_q, wready_q, bvalid_q, bvalid_d;
	logic [1:0] bresp_q;
	logic aw_fire, w_fire, wr_do;
	logic [31:0] strb_mask, wr_bits;
	int wr_idx;

	assign aw_fire = awvalid && awready_q;
	assign w_fire = wvalid && wready_q;
	assign wr_do = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_idx = rw_index(awaddr_q);

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			strb_mask[8*b +: 8] = {8{wstrb_q[b]}};
		end
	end
	assign wr_bits = wdata_q & strb_mask;

	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		bvalid_d = bvalid_q;
		if (aw_fire) begin
			aw_hold_d = 1'b1;
		end
		if (w_fire) begin
			w_hold_d = 1'b1;
		end
		if (wr_do) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= !aw_hold_d && !bvalid_d;
			wready_q <= !w_hold_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			if (aw_fire) begin
				awaddr_q <= awaddr;
			end
			if (w_fire) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_do) begin
				bresp_q <= (wr_idx < RW_COUNT || reads_zero(awaddr_q)
					|| is_reg(awaddr_q, OFS_IRQ_MASK) || is_reg(awaddr_q, OFS_EVENT_STATUS)
					|| is_reg(awaddr_q, OFS_CHANNEL_STATUS)) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	logic wr_ctl, wr_thr, wr_ier, wr_idr, clear_cmd;
	assign wr_ctl = wr_do && is_reg(awaddr_q, OFS_SERIAL_CONTROL);
	assign wr_thr = wr_do && is_reg(awaddr_q, OFS_TX_HOLDING);
	assign wr_ier = wr_do && is_reg(awaddr_q, OFS_IRQ_ENABLE);
	assign wr_idr = wr_do && is_reg(awaddr_q, OFS_IRQ_DISABLE);
	assign clear_cmd = wr_ctl && wr_bits[CTL_CLEAR_STATUS];

	logic [31:0] rw_q [RW_COUNT];
	for (genvar g = 0; g < RW_COUNT; g++) begin : g_rw
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rw_q[g] <= RW_RESET[g];
			end else if (wr_do && wr_idx == g) begin
				rw_q[g] <= (rw_q[g] & ~strb_mask) | wr_bits;
			end
		end
	end
	assign serial_mode_sel = rw_q[RW_SERIAL_MODE][3:0];

	logic is_master, is_slave;
	assign is_master = serial_mode_sel == MODE_LIN_MASTER;
	assign is_slave = serial_mode_sel == MODE_LIN_SLAVE;

	// Transmitter holding register and enable.
	logic tx_en_q, tx_en_d, hold_full_q, hold_full_d, tx_empty_q, char_valid_q;
	logic [CHAR_W-1:0] tx_char_q;

	always_comb begin
		tx_en_d = tx_en_q;
		if (wr_ctl && wr_bits[CTL_TX_ENABLE]) begin
			tx_en_d = 1'b1;
		end
		if (wr_ctl && wr_bits[CTL_TX_DISABLE]) begin
			tx_en_d = 1'b0;
		end
		hold_full_d = hold_full_q;
		if (tx_char_taken && hold_full_q) begin
			hold_full_d = 1'b0;
		end
		if (wr_thr) begin
			hold_full_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_en_q <= 1'b0;
			hold_full_q <= 1'b0;
			tx_char_q <= '0;
			tx_empty_q <= 1'b0;
			char_valid_q <= 1'b0;
		end else begin
			tx_en_q <= tx_en_d;
			hold_full_q <= hold_full_d;
			if (wr_thr) begin
				tx_char_q <= wdata_q[CHAR_W-1:0];
			end
			tx_empty_q <= tx_en_d && !hold_full_d && !tx_shift_busy;
			char_valid_q <= tx_en_d && hold_full_d;
		end
	end
	assign tx_char = tx_char_q;
	assign tx_char_valid = char_valid_q;
	assign tx_enabled = tx_en_q;

	// Sticky LIN flags; a set in the clear cycle wins.
	logic [31:0] lin_set, lin_flags_q, lin_flags_d;
	logic line_level_q;

	always_comb begin
		lin_set = 32'h0;
		lin_set[ST_BREAK] = (is_master && lin_events.break_sent)
			|| (is_slave && lin_events.break_rcvd);
		lin_set[ST_IDENT] = (is_master && lin_events.ident_sent)
			|| (is_slave && lin_events.ident_rcvd);
		lin_set[ST_DONE] = lin_events.transfer_done;
		lin_set[ST_BIT_ERR] = lin_events.bit_error;
		lin_set[ST_SYNC_FIELD_ERR] = is_slave
			&& lin_events.sync_field_error;
		lin_set[ST_PARITY_ERR] = lin_events.ident_parity_error;
		lin_set[ST_CHECKSUM_ERR] = lin_events.checksum_error;
		lin_set[ST_NO_RESP_ERR] = lin_events.no_response_error;
		lin_set[ST_SYNC_TOL_ERR] = lin_events.sync_tolerance_error;
		lin_flags_d = (clear_cmd ? 32'h0 : lin_flags_q) | lin_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lin_flags_q <= 32'h0;
			line_level_q <= 1'b0;
		end else begin
			lin_flags_q <= lin_flags_d;
			line_level_q <= lin_line_in;
		end
	end

	logic [31:0] chan_status;
	always_comb begin
		chan_status = lin_flags_q;
		chan_status[ST_TX_ALL_EMPTY] = tx_empty_q;
		chan_status[ST_LINE_LEVEL] = line_level_q;
	end

	// Read channel.
	logic arready_q, rvalid_q, ar_fire, rd_event;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	int rd_idx;
	assign ar_fire = arvalid && arready_q;
	assign rd_idx = rw_index(araddr);
	assign rd_event = ar_fire && is_reg(araddr, OFS_EVENT_STATUS);

	// Interrupt events, mask and read-to-clear status.
	logic [31:0] ev_q, ev_set, mask_q;
	logic empty_prev_q, irq_q;
	always_comb begin
		ev_set = lin_set;
		ev_set[ST_TX_ALL_EMPTY] = tx_empty_q && !empty_prev_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_q <= 32'h0;
			mask_q <= 32'h0;
			empty_prev_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ev_q <= (rd_event ? 32'h0 : ev_q) | ev_set;
			if (wr_ier) begin
				mask_q <= mask_q | wr_bits;
			end else if (wr_idr) begin
				mask_q <= mask_q & ~wr_bits;
			end
			empty_prev_q <= tx_empty_q;
			irq_q <= |(ev_q & mask_q);
		end
	end
	assign irq = irq_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else begin
			if (ar_fire) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= RESP_OKAY;
				if ((araddr >> 12) != '0) begin
					rdata_q <= 32'h0;
					rresp_q <= RESP_SLVERR;
				end else if (rd_idx < RW_COUNT) begin
					rdata_q <= rw_q[rd_idx];
				end else if (is_reg(araddr, OFS_CHANNEL_STATUS)) begin
					rdata_q <= chan_status;
				end else if (is_reg(araddr, OFS_IRQ_MASK)) begin
					rdata_q <= mask_q;
				end else if (rd_event) begin
					rdata_q <= ev_q;
				end else if (reads_zero(araddr)) begin
					rdata_q <= 32'h0;
				end else begin
					rdata_q <= 32'h0;
					rresp_q <= RESP_SLVERR;
				end
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end else if (!rvalid_q) begin
				arready_q <= 1'b1;
			end
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Checks.
	sequence seq_thr_write;
		wr_thr;
	endsequence
	sequence seq_quiet_clear;
		clear_cmd && (lin_set == 32'h0);
	endsequence
	a_empty_needs_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_empty_q |-> tx_en_q && !hold_full_q && $past(!tx_shift_busy))
		else $error("tx empty while a character is held");
	a_thr_clears_empty: assert property (@(posedge aclk)
		disable iff (!aresetn) seq_thr_write |=> !tx_empty_q ##1 1'b1)
		else $error("tx empty not cleared by holding write");
	a_master_break: assert property (@(posedge aclk) disable iff (!aresetn)
		is_master && lin_events.break_sent |=> lin_flags_q[ST_BREAK])
		else $error("break sent not flagged");
	a_slave_break: assert property (@(posedge aclk) disable iff (!aresetn)
		(!lin_flags_q[ST_BREAK] && !lin_events.break_sent && !is_slave)
		|=> !lin_flags_q[ST_BREAK])
		else $error("break flag set outside its mode");
	a_ident_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_master && lin_events.ident_sent)
		|| (is_slave && lin_events.ident_rcvd)
		|=> lin_flags_q[ST_IDENT])
		else $error("identifier not flagged");
	a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		lin_events.transfer_done |=> lin_flags_q[ST_DONE][*2]
		or (lin_flags_q[ST_DONE] && clear_cmd))
		else $error("transfer done not flagged");
	a_line_level: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 chan_status[ST_LINE_LEVEL] == $past(lin_line_in))
		else $error("line level does not follow the bus");
	a_bit_err_sticky: assert property (@(posedge aclk)
		disable iff (!aresetn)
		lin_flags_q[ST_BIT_ERR] && !clear_cmd |=> lin_flags_q[ST_BIT_ERR])
		else $error("bit error flag dropped");
	a_sync_field_slave: assert property (@(posedge aclk)
		disable iff (!aresetn) !lin_flags_q[ST_SYNC_FIELD_ERR]
		&& !(is_slave && lin_events.sync_field_error)
		|=> !lin_flags_q[ST_SYNC_FIELD_ERR])
		else $error("sync field error set outside slave mode");
	a_parity_err_set: assert property (@(posedge aclk)
		disable iff (!aresetn) lin_events.ident_parity_error
		|=> lin_flags_q[ST_PARITY_ERR])
		else $error("parity error not flagged");
	a_checksum_err_set: assert property (@(posedge aclk)
		disable iff (!aresetn) lin_events.checksum_error
		|=> lin_flags_q[ST_CHECKSUM_ERR])
		else $error("checksum error not flagged");
	a_no_resp_sticky: assert property (@(posedge aclk)
		disable iff (!aresetn) lin_flags_q[ST_NO_RESP_ERR] && !clear_cmd
		|=> lin_flags_q[ST_NO_RESP_ERR])
		else $error("no response flag dropped");
	a_sync_tol_quiet: assert property (@(posedge aclk)
		disable iff (!aresetn) !lin_flags_q[ST_SYNC_TOL_ERR]
		&& !lin_events.sync_tolerance_error
		|=> !lin_flags_q[ST_SYNC_TOL_ERR])
		else $error("sync tolerance flag set without cause");
	a_clear_cmd_flags: assert property (@(posedge aclk)
		disable iff (!aresetn) seq_quiet_clear |=> lin_flags_q == 32'h0)
		else $error("status clear left a flag set");
	a_reset_values: assert property (@(posedge aclk)
		!aresetn |=> lin_flags_q == 32'h0 && mask_q == 32'h0)
		else $error("flags or mask not clear after reset");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 irq_q == $past(|(ev_q & mask_q)))
		else $error("interrupt does not follow masked status");
endmodule : serial_status

// File: design/serial_status_pkg.sv
package serial_status_pkg;

	// Byte offsets of the register map.
	localparam logic [11:0] OFS_PROTOCOL_SELECT = 12'h000;
	localparam logic [11:0] OFS_SHARED_RX = 12'h010;
	localparam logic [11:0] OFS_SHARED_TX = 12'h020;
	localparam logic [11:0] OFS_SERIAL_CONTROL = 12'h200;
	localparam logic [11:0] OFS_SERIAL_MODE = 12'h204;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h208;
	localparam logic [11:0] OFS_IRQ_DISABLE = 12'h20c;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h210;
	localparam logic [11:0] OFS_CHANNEL_STATUS = 12'h214;
	localparam logic [11:0] OFS_RX_HOLDING = 12'h218;
	localparam logic [11:0] OFS_TX_HOLDING = 12'h21c;
	localparam logic [11:0] OFS_BAUD_GENERATOR = 12'h220;
	localparam logic [11:0] OFS_RX_TIMEOUT = 12'h224;
	localparam logic [11:0] OFS_TX_TIMEGUARD = 12'h228;
	localparam logic [11:0] OFS_CLOCK_RATIO = 12'h240;
	localparam logic [11:0] OFS_ERROR_COUNT = 12'h244;
	localparam logic [11:0] OFS_INFRARED_FILTER = 12'h24c;
	localparam logic [11:0] OFS_MANCHESTER = 12'h250;
	localparam logic [11:0] OFS_LIN_MODE = 12'h254;
	localparam logic [11:0] OFS_LIN_IDENTIFIER = 12'h258;
	localparam logic [11:0] OFS_LIN_BAUD = 12'h25c;
	localparam logic [11:0] OFS_RX_COMPARISON = 12'h290;
	localparam logic [11:0] OFS_FIFO_MODE = 12'h2a0;
	localparam logic [11:0] OFS_FIFO_LEVEL = 12'h2a4;
	localparam logic [11:0] OFS_FIFO_IRQ_ENABLE = 12'h2a8;
	localparam logic [11:0] OFS_FIFO_IRQ_DISABLE = 12'h2ac;
	localparam logic [11:0] OFS_FIFO_IRQ_MASK = 12'h2b0;
	localparam logic [11:0] OFS_EVENT_STATUS = 12'h2c0;

	// Plain read/write storage registers and their reset values.
	localparam int RW_COUNT = 13;
	localparam int RW_SERIAL_MODE = 2;
	localparam logic [11:0] RW_OFFSET [RW_COUNT] = '{
		OFS_PROTOCOL_SELECT, OFS_SHARED_TX, OFS_SERIAL_MODE,
		OFS_BAUD_GENERATOR, OFS_RX_TIMEOUT, OFS_TX_TIMEGUARD,
		OFS_CLOCK_RATIO, OFS_INFRARED_FILTER, OFS_MANCHESTER,
		OFS_LIN_MODE, OFS_LIN_IDENTIFIER, OFS_RX_COMPARISON,
		OFS_FIFO_MODE};
	localparam logic [31:0] RW_RESET [RW_COUNT] = '{
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h174,
		32'h0, 32'hb0011004, 32'h0, 32'h0, 32'h0, 32'h0};

	// Registers that read as zero in this block.
	localparam int RZ_COUNT = 12;
	localparam logic [11:0] RZ_OFFSET [RZ_COUNT] = '{
		OFS_SHARED_RX, OFS_SERIAL_CONTROL, OFS_IRQ_ENABLE,
		OFS_IRQ_DISABLE, OFS_RX_HOLDING, OFS_TX_HOLDING,
		OFS_ERROR_COUNT, OFS_LIN_BAUD, OFS_FIFO_LEVEL,
		OFS_FIFO_IRQ_ENABLE, OFS_FIFO_IRQ_DISABLE, OFS_FIFO_IRQ_MASK};

	// Control command bits.
	localparam int CTL_TX_ENABLE = 6;
	localparam int CTL_TX_DISABLE = 7;
	localparam int CTL_CLEAR_STATUS = 8;

	// Status bit positions, shared by status, event status and mask.
	localparam int ST_TX_ALL_EMPTY = 9;
	localparam int ST_BREAK = 13;
	localparam int ST_IDENT = 14;
	localparam int ST_DONE = 15;
	localparam int ST_LINE_LEVEL = 23;
	localparam int ST_BIT_ERR = 25;
	localparam int ST_SYNC_FIELD_ERR = 26;
	localparam int ST_PARITY_ERR = 27;
	localparam int ST_CHECKSUM_ERR = 28;
	localparam int ST_NO_RESP_ERR = 29;
	localparam int ST_SYNC_TOL_ERR = 30;

	localparam logic [3:0] MODE_LIN_MASTER = 4'ha;
	localparam logic [3:0] MODE_LIN_SLAVE = 4'hb;
	localparam int CHAR_W = 9;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// One-cycle event pulses from the LIN frame engine.
	typedef struct packed {
		logic break_sent;
		logic break_rcvd;
		logic ident_sent;
		logic ident_rcvd;
		logic transfer_done;
		logic bit_error;
		logic sync_field_error;
		logic ident_parity_error;
		logic checksum_error;
		logic no_response_error;
		logic sync_tolerance_error;
	} lin_events_type;

endpackage : serial_status_pkg

// File: sim/lin_far_side.sv
`timescale 1ns/1ps
module lin_far_side
	import serial_status_pkg::*;
#(
	parameter int TAKE_DELAY = 12,
	parameter int SHIFT_CYCLES = 20
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Transmit shifter.
	input wire logic tx_char_valid,
	output logic tx_char_taken,
	output logic tx_shift_busy,
	// LIN engine, commanded by the bench.
	input wire lin_events_type ev_cmd,
	input wire logic line_cmd,
	output lin_events_type lin_events,
	output logic lin_line_in
);
	int wait_q;
	int shift_q;

	assign tx_shift_busy = (shift_q != 0);

	// The shifter takes a character only after a delay and then stays busy for SHIFT_CYCLES cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q <= 0;
			shift_q <= 0;
			tx_char_taken <= 1'b0;
			lin_events <= '0;
			lin_line_in <= 1'b0;
		end else begin
			tx_char_taken <= 1'b0;
			lin_events <= ev_cmd;
			lin_line_in <= line_cmd;
			if (shift_q != 0) begin
				shift_q <= shift_q - 1;
			end
			if (tx_char_valid && shift_q == 0 && !tx_char_taken) begin
				if (wait_q == TAKE_DELAY) begin
					tx_char_taken <= 1'b1;
					wait_q <= 0;
					shift_q <= SHIFT_CYCLES;
				end else begin
					wait_q <= wait_q + 1;
				end
			end
		end
	end
endmodule : lin_far_side

// File: sim/serial_status_tb_top.sv
`timescale 1ns/1ps
module serial_status_tb_top;
	import serial_status_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic txv, taken, busy, line_in, tx_en_o;
	logic [8:0] tx_char_o;
	logic [3:0] mode_o;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	lin_events_type ev_cmd = '0;
	lin_events_type events;
	lin_events_type ev;
	logic line_cmd = 1'b0;
	logic [3:0] m;
	logic [33:0] rq[$];
	logic [1:0] wq[$];
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rnd = 32'd94167;

	always #5 aclk = ~aclk;

	serial_status dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .tx_char(tx_char_o), .tx_char_valid(txv),
		.tx_char_taken(taken), .tx_shift_busy(busy), .tx_enabled(tx_en_o),
		.serial_mode_sel(mode_o), .lin_events(events), .lin_line_in(line_in),
		.irq(irq));

	lin_far_side far (.aclk(aclk), .aresetn(aresetn), .tx_char_valid(txv),
		.tx_char_taken(taken), .tx_shift_busy(busy), .ev_cmd(ev_cmd),
		.line_cmd(line_cmd), .lin_events(events), .lin_line_in(line_in));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	function automatic logic [31:0] rst_of(input logic [11:0] a);
		if (a == OFS_MANCHESTER) begin
			return 32'hb0011004;
		end
		return (a == OFS_CLOCK_RATIO) ? 32'h174 : 32'h0;
	endfunction : rst_of

	function automatic logic [31:0] st_exp(input logic [3:0] md,
		input lin_events_type e);
		logic [31:0] s;
		logic ma;
		logic sl;
		s = 32'h0;
		ma = (md == MODE_LIN_MASTER);
		sl = (md == MODE_LIN_SLAVE);
		s[ST_BREAK] = (ma && e.break_sent) || (sl && e.break_rcvd);
		s[ST_IDENT] = (ma && e.ident_sent) || (sl && e.ident_rcvd);
		s[ST_DONE] = e.transfer_done;
		s[ST_LINE_LEVEL] = line_cmd;
		s[ST_BIT_ERR] = e.bit_error;
		s[ST_SYNC_FIELD_ERR] = sl && e.sync_field_error;
		s[ST_PARITY_ERR] = e.ident_parity_error;
		s[ST_CHECKSUM_ERR] = e.checksum_error;
		s[ST_NO_RESP_ERR] = e.no_response_error;
		s[ST_SYNC_TOL_ERR] = e.sync_tolerance_error;
		return s;
	endfunction : st_exp

	task check(input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// Results are compared against the oldest note when they appear.
	always @(posedge aclk) begin
		cycles++;
		if (rvalid && rready) begin
			check({rresp, rdata}, rq.pop_front());
		end
		if (bvalid && bready) begin
			check(bresp, wq.pop_front());
		end
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		wq.push_back(er);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		rq.push_back({er, d});
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : rd

	task pulse(input lin_events_type e);
		@(posedge aclk);
		ev_cmd <= e;
		@(posedge aclk);
		ev_cmd <= '0;
		repeat (3) @(posedge aclk);
	endtask : pulse

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < RW_COUNT; i++) begin
			rd(RW_OFFSET[i], rst_of(RW_OFFSET[i]), RESP_OKAY);
		end
		rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		rd(OFS_CHANNEL_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_EVENT_STATUS, 32'h0, RESP_OKAY);
		for (int i = 0; i < RW_COUNT; i++) begin
			rnd = xs(rnd);
			wr(RW_OFFSET[i], rnd, RESP_OKAY);
			rd(RW_OFFSET[i], rnd, RESP_OKAY);
		end
		for (int i = 0; i < RZ_COUNT; i++) begin
			rd(RZ_OFFSET[i], 32'h0, RESP_OKAY);
		end
		// Only the second byte lane of a strobed write may land.
		wr(OFS_BAUD_GENERATOR, 32'h0, RESP_OKAY);
		wstrb <= 4'h2;
		wr(OFS_BAUD_GENERATOR, 32'hffffffff, RESP_OKAY);
		wstrb <= 4'hf;
		rd(OFS_BAUD_GENERATOR, 32'hff00, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'hffffffff, RESP_OKAY);
		rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		wr(12'h300, 32'h1, RESP_SLVERR);
		rd(12'h004, 32'h0, RESP_SLVERR);
		wr(OFS_SERIAL_MODE, 32'h0, RESP_OKAY);
		line_cmd <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(OFS_CHANNEL_STATUS, 32'h1 << ST_LINE_LEVEL, RESP_OKAY);
		// Only the unmasked bit error may raise the interrupt.
		wr(OFS_IRQ_ENABLE, 32'h1 << ST_BIT_ERR, RESP_OKAY);
		rd(OFS_IRQ_MASK, 32'h1 << ST_BIT_ERR, RESP_OKAY);
		ev = '0;
		ev.bit_error = 1'b1;
		pulse(ev);
		check(irq, 1'b1);
		rd(OFS_EVENT_STATUS, 32'h1 << ST_BIT_ERR, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		ev = '0;
		ev.checksum_error = 1'b1;
		pulse(ev);
		check(irq, 1'b0);
		rd(OFS_EVENT_STATUS, 32'h1 << ST_CHECKSUM_ERR, RESP_OKAY);
		wr(OFS_IRQ_DISABLE, 32'h1 << ST_BIT_ERR, RESP_OKAY);
		rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		// Enable the transmitter and clear the flags in one command.
		wr(OFS_SERIAL_CONTROL, 32'h140, RESP_OKAY);
		check(tx_en_o, 1'b1);
		repeat (3) @(posedge aclk);
		rd(OFS_CHANNEL_STATUS, 32'h800200, RESP_OKAY);
		wr(OFS_TX_HOLDING, 32'h1a5, RESP_OKAY);
		check(tx_char_o, 9'h1a5);
		rd(OFS_CHANNEL_STATUS, 32'h800000, RESP_OKAY);
		repeat (16) @(posedge aclk);
		rd(OFS_CHANNEL_STATUS, 32'h800000, RESP_OKAY);
		repeat (30) @(posedge aclk);
		rd(OFS_CHANNEL_STATUS, 32'h800200, RESP_OKAY);
		wr(OFS_SERIAL_CONTROL, 32'h80, RESP_OKAY);
		check(tx_en_o, 1'b0);
		rd(OFS_CHANNEL_STATUS, 32'h800000, RESP_OKAY);
		for (int k = 0; k < 12; k++) begin
			rnd = xs(rnd);
			m = (k % 3 == 0) ? MODE_LIN_MASTER :
				(k % 3 == 1) ? MODE_LIN_SLAVE : rnd[15:12];
			wr(OFS_SERIAL_MODE, {28'h0, m}, RESP_OKAY);
			check(mode_o, m);
			wr(OFS_SERIAL_CONTROL, 32'h100, RESP_OKAY);
			ev = lin_events_type'(rnd[10:0]);
			pulse(ev);
			rd(OFS_CHANNEL_STATUS, st_exp(m, ev), RESP_OKAY);
			rd(OFS_CHANNEL_STATUS, st_exp(m, ev), RESP_OKAY);
			wr(OFS_SERIAL_CONTROL, 32'h100, RESP_OKAY);
			rd(OFS_CHANNEL_STATUS, st_exp(m, '0), RESP_OKAY);
		end
		check(irq, 1'b0);
		tally_and_finish();
	end
endmodule : serial_status_tb_top
